// ==== common/ipm_pkg.sv ====
// Package for the inter-processor mailbox and FIFO block
`default_nettype none
package ipm_pkg;
    // Register indices on each side's register port (no offsets printed)
    localparam logic [4:0] M_FIFO_CS = 5'h00;
    localparam logic [4:0] M_RX_DATA = 5'h01;
    localparam logic [4:0] M_TX_DATA = 5'h02;
    localparam logic [4:0] M_MBX_BASE = 5'h10;
    localparam logic [4:0] S_CTRL = 5'h00;
    localparam logic [4:0] S_STAT = 5'h01;
    localparam logic [4:0] S_MBX_RDY = 5'h02;
    localparam logic [4:0] S_FIFO_CS = 5'h03;
    localparam logic [4:0] S_TX_DATA = 5'h04;
    localparam logic [4:0] S_RX_DATA = 5'h05;
    localparam logic [4:0] S_MBX_BASE = 5'h10;
    // FIFO status field positions, m2s in the upper byte, s2m in the lower
    localparam int M2S_EN_BIT = 15;
    localparam int M2S_OF_BIT = 11;
    localparam int M2S_UF_BIT = 10;
    localparam int M2S_FULL_BIT = 9;
    localparam int M2S_EMPTY_BIT = 8;
    localparam int S2M_EN_BIT = 7;
    localparam int S2M_OF_BIT = 3;
    localparam int S2M_UF_BIT = 2;
    localparam int S2M_FULL_BIT = 1;
    localparam int S2M_EMPTY_BIT = 0;
    // Slave control and status field positions
    localparam int THR_LSB = 10;
    localparam int REQ_BIT = 9;
    localparam int ACK_BIT = 8;
    localparam int MRST_IE_BIT = 7;
    localparam int MRST_BIT = 15;
    localparam int PWR_LSB = 12;
    // Threshold codes
    localparam logic [1:0] THR_FIRST = 2'h0;
    localparam logic [1:0] THR_HALF = 2'h1;
    localparam logic [1:0] THR_3Q = 2'h2;
    localparam logic [1:0] THR_FULL = 2'h3;
    // Reset values
    localparam logic [15:0] ZERO16 = 16'h0000;
    // Register access bundle
    typedef struct packed {
        logic wr;
        logic rd;
        logic [4:0] addr;
        logic [15:0] wdata;
    } ipm_req_t;
endpackage
`default_nettype wire

// ==== src/ipm_mailbox.sv ====
// Inter-processor mailbox, FIFOs and cross requests between two cores
// Notes on behaviour
// R1: Direction bit one: slave writes, master read-only
// R2: Direction bit zero: master writes, resets zero
// R3: Eight ready flags set by transmitter write
// R4: Bit 15 enables m2s FIFO, clearing empties
// R5: Bit 7 enables s2m FIFO, clearing empties
// R6: m2s overflow/underflow sticky until disable
// R7: m2s full flag after filling write
// R8: m2s empty flag, reset one
// R9: Disable sets empty until master writes
// R10: s2m full flag after filling write
// R11: s2m empty flag, reset one
// R12: s2m overflow bit 3, underflow bit 2
// R13: Oldest s2m word on master data-out
// R14: Threshold selects s2m data-valid interrupt
// R15: Slave request bit 9 interrupts master
// R16: Acknowledge without request is protocol error
// R17: Master-reset interrupt gated by enable bit 7
// R18: Master-in-reset status, rising edge interrupts
// R19: Master low-power state two-bit field
// R20: Mirror master request and acknowledge to slave
// R21: Slave sees both FIFOs' status bits
// R22: Slave push and pop data registers
// R23: FIFO depth parameter 16 to 32
// R24: Overflow on full write, underflow empty read
`timescale 1ns/1ps
`default_nettype none
module ipm_mailbox #(
    parameter int DEPTH = 16,
    parameter logic [15:0] MBX_DIR = 16'h0000,
    parameter logic [15:0] HS_EN = 16'hFFFF
) (
    input wire logic clk,
    input wire logic rst,
    input wire ipm_pkg::ipm_req_t m_req,
    output logic [15:0] m_rdata,
    input wire ipm_pkg::ipm_req_t s_req,
    output logic [15:0] s_rdata,
    input wire logic m_irq_req,
    input wire logic m_ack,
    input wire logic m_in_reset,
    input wire logic [1:0] m_low_power,
    output logic s2m_req_irq,
    output logic s_ack_out,
    output logic s_ack_err,
    output logic m_ack_err,
    output logic m_rst_irq,
    output logic s2m_valid_irq
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = AW + 1;
    ////////////////////////////////////////////////////////////////////////
    // Register state
    logic [15:0] mbx_r [16]; // Mailbox words
    logic [7:0] rdy_r; // Ready flags A..H, one per low mailbox word
    logic [15:0] m2s_mem_r [DEPTH];
    logic [15:0] s2m_mem_r [DEPTH];
    logic [AW-1:0] m2s_wp_r, m2s_rp_r, s2m_wp_r, s2m_rp_r;
    logic [CW-1:0] m2s_cnt_r, s2m_cnt_r;
    logic m2s_en_r, s2m_en_r; // Enable controls
    logic m2s_of_r, m2s_uf_r, s2m_of_r, s2m_uf_r; // Sticky error flags
    logic [1:0] thr_r; // Data-valid threshold
    logic req_r, ack_r, mrst_ie_r; // Slave control bits
    logic mrst_d_r; // Previous master-reset level
    logic [15:0] m_rdata_r, s_rdata_r;
    // Pointer advance, wrapping at the parameterised depth
    function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
        bump = (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
    endfunction
    // Mailbox index decode
    function automatic logic is_mbx(input logic [4:0] a);
        is_mbx = a[4];
    endfunction
    ////////////////////////////////////////////////////////////////////////
    // Access decode
    wire logic m2s_push = m_req.wr && m_req.addr == ipm_pkg::M_TX_DATA && m2s_en_r;
    wire logic m2s_pop = s_req.rd && s_req.addr == ipm_pkg::S_RX_DATA && m2s_en_r;
    wire logic s2m_push = s_req.wr && s_req.addr == ipm_pkg::S_TX_DATA && s2m_en_r;
    wire logic s2m_pop = m_req.rd && m_req.addr == ipm_pkg::M_RX_DATA && s2m_en_r;
    wire logic m2s_full = m2s_cnt_r == CW'(DEPTH);
    wire logic m2s_empty = m2s_cnt_r == '0;
    wire logic s2m_full = s2m_cnt_r == CW'(DEPTH);
    wire logic s2m_empty = s2m_cnt_r == '0;
    wire logic m2s_wok = m2s_push && !m2s_full; // R24
    wire logic m2s_rok = m2s_pop && !m2s_empty; // R24
    wire logic s2m_wok = s2m_push && !s2m_full; // R24
    wire logic s2m_rok = s2m_pop && !s2m_empty; // R24
    ////////////////////////////////////////////////////////////////////////
    // Mailbox words and ready flags
    always_ff @(posedge clk) begin
        if (rst) begin
            for (int i = 0; i < 16; i++) begin
                mbx_r[i] <= ipm_pkg::ZERO16; // R2
            end
            rdy_r <= '0;
        end else begin
            for (int i = 0; i < 16; i++) begin
                // Master owns the word when its direction bit is zero
                if (!MBX_DIR[i] && m_req.wr && is_mbx(m_req.addr)
                    && m_req.addr[3:0] == 4'(i)) begin
                    mbx_r[i] <= m_req.wdata; // R2
                end else if (MBX_DIR[i] && s_req.wr && is_mbx(s_req.addr)
                             && s_req.addr[3:0] == 4'(i)) begin
                    mbx_r[i] <= s_req.wdata; // R1
                end
            end
            for (int i = 0; i < 8; i++) begin
                // Flag i tracks word i; the receiver's read drains it, a write sets it
                if (!HS_EN[i]) begin
                    rdy_r[i] <= 1'b0; // R3
                end else if ((!MBX_DIR[i] && m_req.wr && is_mbx(m_req.addr)
                              && m_req.addr[3:0] == 4'(i))
                             || (MBX_DIR[i] && s_req.wr && is_mbx(s_req.addr)
                                 && s_req.addr[3:0] == 4'(i))) begin
                    rdy_r[i] <= 1'b1; // R3
                end else if ((!MBX_DIR[i] && s_req.rd && is_mbx(s_req.addr)
                              && s_req.addr[3:0] == 4'(i))
                             || (MBX_DIR[i] && m_req.rd && is_mbx(m_req.addr)
                                 && m_req.addr[3:0] == 4'(i))) begin
                    rdy_r[i] <= 1'b0;
                end
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // Master control: FIFO enables
    always_ff @(posedge clk) begin
        if (rst) begin
            m2s_en_r <= 1'b0;
            s2m_en_r <= 1'b0;
        end else if (m_req.wr && m_req.addr == ipm_pkg::M_FIFO_CS) begin
            m2s_en_r <= m_req.wdata[ipm_pkg::M2S_EN_BIT]; // R4
            s2m_en_r <= m_req.wdata[ipm_pkg::S2M_EN_BIT]; // R5
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // Master-to-slave FIFO; disable returns it to empty
    always_ff @(posedge clk) begin
        if (rst || !m2s_en_r) begin
            m2s_wp_r <= '0; // R4
            m2s_rp_r <= '0;
            m2s_cnt_r <= '0; // R9
        end else begin
            if (m2s_wok) begin
                m2s_wp_r <= bump(m2s_wp_r);
            end
            if (m2s_rok) begin
                m2s_rp_r <= bump(m2s_rp_r);
            end
            m2s_cnt_r <= CW'(m2s_cnt_r + CW'(m2s_wok) - CW'(m2s_rok)); // R7 R8
        end
    end
    // Storage needs no reset; pointers guard it
    always_ff @(posedge clk) begin
        if (m2s_wok) begin
            m2s_mem_r[m2s_wp_r] <= m_req.wdata; // R23
        end
        if (s2m_wok) begin
            s2m_mem_r[s2m_wp_r] <= s_req.wdata; // R22
        end
    end
    // Sticky errors; only a disable clears the m2s pair
    always_ff @(posedge clk) begin
        if (rst || !m2s_en_r) begin
            m2s_of_r <= 1'b0; // R6
            m2s_uf_r <= 1'b0; // R6
        end else begin
            if (m2s_push && m2s_full) begin
                m2s_of_r <= 1'b1; // R24
            end
            if (m2s_pop && m2s_empty) begin
                m2s_uf_r <= 1'b1; // R24
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // Slave-to-master FIFO
    always_ff @(posedge clk) begin
        if (rst || !s2m_en_r) begin
            s2m_wp_r <= '0; // R5
            s2m_rp_r <= '0;
            s2m_cnt_r <= '0;
        end else begin
            if (s2m_wok) begin
                s2m_wp_r <= bump(s2m_wp_r);
            end
            if (s2m_rok) begin
                s2m_rp_r <= bump(s2m_rp_r);
            end
            s2m_cnt_r <= CW'(s2m_cnt_r + CW'(s2m_wok) - CW'(s2m_rok)); // R10 R11
        end
    end
    // Overflow cleared by disable; underflow also by a master write of 0
    always_ff @(posedge clk) begin
        if (rst || !s2m_en_r) begin
            s2m_of_r <= 1'b0;
            s2m_uf_r <= 1'b0;
        end else begin
            if (s2m_push && s2m_full) begin
                s2m_of_r <= 1'b1; // R12
            end
            // Set beats clear when both land together
            if (s2m_pop && s2m_empty) begin
                s2m_uf_r <= 1'b1; // R12
            end else if (m_req.wr && m_req.addr == ipm_pkg::M_FIFO_CS
                         && !m_req.wdata[ipm_pkg::S2M_UF_BIT]) begin
                s2m_uf_r <= 1'b0; // R12
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // Data-valid interrupt after a slave write reaches the threshold
    logic [CW-1:0] thr_lvl;
    always_comb begin
        case (thr_r)
            ipm_pkg::THR_FULL: thr_lvl = CW'(DEPTH);
            ipm_pkg::THR_3Q: thr_lvl = CW'((DEPTH * 3) / 4);
            ipm_pkg::THR_HALF: thr_lvl = CW'(DEPTH / 2);
            default: thr_lvl = CW'(1);
        endcase
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            s2m_valid_irq <= 1'b0;
        end else begin
            // A pop in the same cycle leaves the level where it was
            s2m_valid_irq <= s2m_wok
                             && (CW'(s2m_cnt_r + 1'b1 - CW'(s2m_rok)) >= thr_lvl); // R14
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // Slave control register
    always_ff @(posedge clk) begin
        if (rst) begin
            thr_r <= ipm_pkg::THR_FIRST;
            req_r <= 1'b0;
            ack_r <= 1'b0;
            mrst_ie_r <= 1'b0;
        end else if (s_req.wr && s_req.addr == ipm_pkg::S_CTRL) begin
            thr_r <= s_req.wdata[ipm_pkg::THR_LSB +: 2]; // R14
            req_r <= s_req.wdata[ipm_pkg::REQ_BIT]; // R15
            ack_r <= s_req.wdata[ipm_pkg::ACK_BIT]; // R16
            mrst_ie_r <= s_req.wdata[ipm_pkg::MRST_IE_BIT]; // R17
        end
    end
    // Request, ack and protocol-error levels toward the master
    always_ff @(posedge clk) begin
        if (rst) begin
            s2m_req_irq <= 1'b0;
            s_ack_out <= 1'b0;
            s_ack_err <= 1'b0;
            m_ack_err <= 1'b0;
        end else begin
            s2m_req_irq <= req_r; // R15
            s_ack_out <= ack_r; // R16
            s_ack_err <= ack_r && !m_irq_req; // R16
            m_ack_err <= m_ack && !req_r; // R16
        end
    end
    // Master-reset event, one pulse on the rising edge of the status
    always_ff @(posedge clk) begin
        if (rst) begin
            mrst_d_r <= 1'b0;
            m_rst_irq <= 1'b0;
        end else begin
            mrst_d_r <= m_in_reset;
            m_rst_irq <= mrst_ie_r && m_in_reset && !mrst_d_r; // R17 R18
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // Status words
    logic [15:0] fifo_cs;
    always_comb begin
        fifo_cs = ipm_pkg::ZERO16;
        fifo_cs[ipm_pkg::M2S_EN_BIT] = m2s_en_r; // R21
        fifo_cs[ipm_pkg::M2S_OF_BIT] = m2s_of_r;
        fifo_cs[ipm_pkg::M2S_UF_BIT] = m2s_uf_r;
        fifo_cs[ipm_pkg::M2S_FULL_BIT] = m2s_full; // R7
        fifo_cs[ipm_pkg::M2S_EMPTY_BIT] = m2s_empty; // R8
        fifo_cs[ipm_pkg::S2M_EN_BIT] = s2m_en_r;
        fifo_cs[ipm_pkg::S2M_OF_BIT] = s2m_of_r; // R12
        fifo_cs[ipm_pkg::S2M_UF_BIT] = s2m_uf_r; // R12
        fifo_cs[ipm_pkg::S2M_FULL_BIT] = s2m_full; // R10
        fifo_cs[ipm_pkg::S2M_EMPTY_BIT] = s2m_empty; // R11
    end
    logic [15:0] s_stat;
    always_comb begin
        s_stat = ipm_pkg::ZERO16;
        s_stat[ipm_pkg::MRST_BIT] = m_in_reset; // R18
        // Reserved code passes through unchanged
        s_stat[ipm_pkg::PWR_LSB +: 2] = m_low_power; // R19
        s_stat[ipm_pkg::REQ_BIT] = m_irq_req; // R20
        s_stat[ipm_pkg::ACK_BIT] = m_ack; // R20
    end
    ////////////////////////////////////////////////////////////////////////
    // Read data, registered; a read takes effect the cycle it is presented
    always_ff @(posedge clk) begin
        if (rst) begin
            m_rdata_r <= ipm_pkg::ZERO16; // R13
        end else if (m_req.rd) begin
            if (is_mbx(m_req.addr)) begin
                m_rdata_r <= mbx_r[m_req.addr[3:0]];
            end else if (m_req.addr == ipm_pkg::M_FIFO_CS) begin
                m_rdata_r <= fifo_cs;
            end else if (m_req.addr == ipm_pkg::M_RX_DATA) begin
                m_rdata_r <= s2m_empty ? ipm_pkg::ZERO16 : s2m_mem_r[s2m_rp_r]; // R13
            end else if (m_req.addr == ipm_pkg::M_TX_DATA) begin
                m_rdata_r <= ipm_pkg::ZERO16;
            end else begin
                m_rdata_r <= ipm_pkg::ZERO16;
            end
        end
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            s_rdata_r <= ipm_pkg::ZERO16;
        end else if (s_req.rd) begin
            if (is_mbx(s_req.addr)) begin
                s_rdata_r <= mbx_r[s_req.addr[3:0]];
            end else begin
                case (s_req.addr)
                    ipm_pkg::S_CTRL: s_rdata_r <= {4'h0, thr_r, req_r, ack_r, mrst_ie_r, 7'h00};
                    ipm_pkg::S_STAT: s_rdata_r <= s_stat;
                    ipm_pkg::S_MBX_RDY: s_rdata_r <= {8'h00, rdy_r[7:0]}; // R3
                    ipm_pkg::S_FIFO_CS: s_rdata_r <= fifo_cs; // R21
                    ipm_pkg::S_RX_DATA: s_rdata_r <= m2s_empty ? ipm_pkg::ZERO16
                                                              : m2s_mem_r[m2s_rp_r]; // R22
                    default: s_rdata_r <= ipm_pkg::ZERO16;
                endcase
            end
        end
    end
    assign m_rdata = m_rdata_r;
    assign s_rdata = s_rdata_r;
    ////////////////////////////////////////////////////////////////////////
    // Checks
    a_m2s_of_sticky: assert property (@(posedge clk) disable iff (rst) // R6
        m2s_of_r && m2s_en_r |=> m2s_of_r) else $error("m2s overflow lost");
    a_m2s_full_set: assert property (@(posedge clk) disable iff (rst) // R7
        m2s_wok && !m2s_rok && m2s_cnt_r == CW'(DEPTH - 1) |=> m2s_full)
        else $error("m2s full missing");
    a_m2s_dis_empty: assert property (@(posedge clk) disable iff (rst) // R9
        !m2s_en_r |=> m2s_empty) else $error("disabled m2s not empty");
    // A push on a full FIFO overflows even beside a master pop; this check takes a lone push
    a_s2m_full_of: assert property (@(posedge clk) disable iff (rst) // R24
        s2m_push && s2m_full && !s2m_pop |=> s2m_of_r && s2m_full)
        else $error("s2m overflow missed");
    a_s2m_uf_set: assert property (@(posedge clk) disable iff (rst) // R12
        s2m_pop && s2m_empty |=> s2m_uf_r) else $error("s2m underflow missed");
    a_mrst_edge_irq: assert property (@(posedge clk) disable iff (rst) // R17
        m_rst_irq |-> $past(m_in_reset) && $past(mrst_ie_r))
        else $error("spurious master reset irq");
    a_req_follows: assert property (@(posedge clk) disable iff (rst) // R15
        $rose(req_r) |=> s2m_req_irq) else $error("request not raised");
    a_ack_err_flag: assert property (@(posedge clk) disable iff (rst) // R16
        ack_r && !m_irq_req |=> s_ack_err) else $error("ack error missed");
    a_s2m_dis_clear: assert property (@(posedge clk) disable iff (rst) // R5
        !s2m_en_r |=> s2m_empty && !s2m_of_r) else $error("s2m disable failed");
    a_m2s_uf_set: assert property (@(posedge clk) disable iff (rst) // R24
        m2s_pop && m2s_empty |=> m2s_uf_r) else $error("m2s underflow missed");
    a_s2m_full_set: assert property (@(posedge clk) disable iff (rst) // R10
        s2m_wok && !s2m_rok && s2m_cnt_r == CW'(DEPTH - 1) |=> s2m_full)
        else $error("s2m full missing");
    a_m2s_empty_hold: assert property (@(posedge clk) disable iff (rst) // R9
        m2s_empty && !m2s_wok |=> m2s_empty) else $error("m2s empty dropped");
    a_mrst_irq_pulse: assert property (@(posedge clk) disable iff (rst) // R18
        m_rst_irq |=> !m_rst_irq) else $error("reset irq too long");
    a_valid_irq_src: assert property (@(posedge clk) disable iff (rst) // R14
        s2m_valid_irq |-> $past(s2m_wok)) else $error("valid irq without write");
    a_s_ack_follows: assert property (@(posedge clk) disable iff (rst) // R16
        $rose(ack_r) |=> s_ack_out) else $error("ack not passed on");
endmodule
`default_nettype wire

// ==== test/ipm_master_model.sv ====
// Behavioural model of the master core that faces the mailbox block
`timescale 1ns/1ps
`default_nettype none
module ipm_master_model (
    input wire logic clk,
    output ipm_pkg::ipm_req_t m_req,
    input wire logic [15:0] m_rdata,
    input wire logic s2m_req_irq,
    output logic m_irq_req,
    output logic m_ack,
    output logic m_in_reset,
    output logic [1:0] m_low_power
);
    int ack_dly = 0; // Cycles the master waits before it acknowledges
    int ack_cnt_r = 0; // Cycles the slave request has stood so far
    // Quiet master at time zero
    initial begin
        m_req = '0;
        m_irq_req = 1'b0;
        m_ack = 1'b0;
        m_in_reset = 1'b0;
        m_low_power = 2'h0;
    end
    // Acknowledge only a standing slave request, and drop with it
    always @(posedge clk) begin
        if (s2m_req_irq) begin
            ack_cnt_r <= ack_cnt_r + 1;
            m_ack <= (ack_cnt_r >= ack_dly);
        end else begin
            ack_cnt_r <= 0;
            m_ack <= 1'b0;
        end
    end
    // Register write, held until the taking edge, then cleared
    task automatic m_wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge clk);
        #1 m_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk);
        #1 m_req = '0;
    endtask
    // Register read, data taken once the registered answer has landed
    task automatic m_rd(input logic [4:0] a, output logic [15:0] d);
        @(posedge clk);
        #1 m_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
        @(posedge clk);
        #1 m_req = '0;
        d = m_rdata;
    endtask
endmodule
`default_nettype wire

// ==== test/ipm_mailbox_tb.sv ====
// Self-checking testbench for the inter-processor mailbox block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin \
    n_errors++; $display("BAD %s exp %0h got %0h", nm, e, g); end end
module ipm_mailbox_tb;
    localparam int DEPTH = 16; // Shortest legal depth keeps runs brief
    logic clk = 1'b0;
    logic rst = 1'b1;
    ipm_pkg::ipm_req_t m_req;
    ipm_pkg::ipm_req_t s_req = '0; // Slave side driven by the bench
    logic [15:0] m_rdata;
    logic [15:0] s_rdata;
    logic m_irq_req, m_ack, m_in_reset;
    logic [1:0] m_low_power;
    logic s2m_req_irq, s_ack_out, s_ack_err, m_ack_err, m_rst_irq, s2m_valid_irq;
    int n_errors = 0;
    int samples_checked = 0;
    logic irq; // Threshold pulse seen around the last slave write
    always #5 clk = ~clk;
    // Word 1 points slave-to-master, all others master-to-slave
    ipm_mailbox #(.DEPTH(DEPTH), .MBX_DIR(16'h0002), .HS_EN(16'hFF7F)) u_ipm_mailbox (
        .clk(clk), .rst(rst), .m_req(m_req), .m_rdata(m_rdata), .s_req(s_req),
        .s_rdata(s_rdata), .m_irq_req(m_irq_req), .m_ack(m_ack),
        .m_in_reset(m_in_reset), .m_low_power(m_low_power), .s2m_req_irq(s2m_req_irq),
        .s_ack_out(s_ack_out), .s_ack_err(s_ack_err), .m_ack_err(m_ack_err),
        .m_rst_irq(m_rst_irq), .s2m_valid_irq(s2m_valid_irq));
    ipm_master_model u_ipm_master_model (
        .clk(clk), .m_req(m_req), .m_rdata(m_rdata), .s2m_req_irq(s2m_req_irq),
        .m_irq_req(m_irq_req), .m_ack(m_ack), .m_in_reset(m_in_reset),
        .m_low_power(m_low_power));
    ////////////////////////////////////////////////////////////////////////////
    // Verdict, reached from the main sequence or the watchdog
    task automatic close_out;
        if (n_errors == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // Slave write; a threshold pulse may land one or two edges later
    task automatic s_wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge clk);
        #1 s_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk);
        #1 s_req = '0;
        irq = s2m_valid_irq;
        @(posedge clk);
        #1 irq = irq | s2m_valid_irq;
    endtask
    // Slave read and compare
    task automatic s_chk(input logic [4:0] a, input logic [15:0] e);
        @(posedge clk);
        #1 s_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
        @(posedge clk);
        #1 s_req = '0;
        `CHK("slave reg", e, s_rdata)
    endtask
    // Master read through the partner and compare
    task automatic m_chk(input logic [4:0] a, input logic [15:0] e);
        logic [15:0] d;
        u_ipm_master_model.m_rd(a, d);
        `CHK("master reg", e, d)
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // Reset values on both sides
    task automatic t_reset;
        m_chk(ipm_pkg::M_FIFO_CS, 16'h0101);
        m_chk(ipm_pkg::M_RX_DATA, 16'h0000);
        m_chk(ipm_pkg::M_MBX_BASE, 16'h0000);
        s_chk(ipm_pkg::S_MBX_RDY, 16'h0000);
    endtask
    // Mailbox words in both directions, with their ready flags
    task automatic t_mbx;
        u_ipm_master_model.m_wr(ipm_pkg::M_MBX_BASE, 16'h1234);
        s_chk(ipm_pkg::S_MBX_RDY, 16'h0001);
        s_chk(ipm_pkg::S_MBX_BASE, 16'h1234);
        s_chk(ipm_pkg::S_MBX_RDY, 16'h0000);
        // Master write to a slave-owned word must leave no trace
        u_ipm_master_model.m_wr(ipm_pkg::M_MBX_BASE + 5'h01, 16'h5555);
        s_chk(ipm_pkg::S_MBX_RDY, 16'h0000);
        // Flag H has its handshake switched off and must stay clear
        u_ipm_master_model.m_wr(ipm_pkg::M_MBX_BASE + 5'h07, 16'h7777);
        s_chk(ipm_pkg::S_MBX_RDY, 16'h0000);
        s_wr(ipm_pkg::S_MBX_BASE + 5'h01, 16'hABCD);
        s_chk(ipm_pkg::S_MBX_RDY, 16'h0002);
        m_chk(ipm_pkg::M_MBX_BASE + 5'h01, 16'hABCD);
        m_chk(ipm_pkg::M_MBX_BASE, 16'h1234);
    endtask
    // Master-to-slave FIFO: fill, overflow, drain, underflow, disable
    task automatic t_m2s;
        u_ipm_master_model.m_wr(ipm_pkg::M_FIFO_CS, 16'h8080);
        for (int i = 0; i < DEPTH; i++) begin
            u_ipm_master_model.m_wr(ipm_pkg::M_TX_DATA, 16'hA500 + 16'(i));
        end
        m_chk(ipm_pkg::M_FIFO_CS, 16'h8281);
        u_ipm_master_model.m_wr(ipm_pkg::M_TX_DATA, 16'hDEAD);
        m_chk(ipm_pkg::M_FIFO_CS, 16'h8A81);
        s_chk(ipm_pkg::S_FIFO_CS, 16'h8A81);
        for (int i = 0; i < DEPTH; i++) begin
            s_chk(ipm_pkg::S_RX_DATA, 16'hA500 + 16'(i));
        end
        s_chk(ipm_pkg::S_FIFO_CS, 16'h8981);
        s_chk(ipm_pkg::S_RX_DATA, 16'h0000);
        m_chk(ipm_pkg::M_FIFO_CS, 16'h8D81);
        u_ipm_master_model.m_wr(ipm_pkg::M_FIFO_CS, 16'h0080);
        m_chk(ipm_pkg::M_FIFO_CS, 16'h0181);
        u_ipm_master_model.m_wr(ipm_pkg::M_FIFO_CS, 16'h8080);
        m_chk(ipm_pkg::M_FIFO_CS, 16'h8181);
        u_ipm_master_model.m_wr(ipm_pkg::M_TX_DATA, 16'h0042);
        m_chk(ipm_pkg::M_FIFO_CS, 16'h8081);
        s_chk(ipm_pkg::S_RX_DATA, 16'h0042);
    endtask
    // Slave-to-master FIFO: every threshold code, then full and drain
    task automatic t_s2m;
        int first [4];
        int hit;
        first = '{1, DEPTH / 2, DEPTH * 3 / 4, DEPTH};
        for (int c = 0; c < 4; c++) begin
            u_ipm_master_model.m_wr(ipm_pkg::M_FIFO_CS, 16'h8000);
            u_ipm_master_model.m_wr(ipm_pkg::M_FIFO_CS, 16'h8080);
            s_wr(ipm_pkg::S_CTRL, {4'h0, c[1:0], 10'h000});
            hit = 0;
            for (int i = 1; i <= DEPTH; i++) begin
                s_wr(ipm_pkg::S_TX_DATA, 16'hC000 + 16'(i));
                if (irq === 1'b1 && hit == 0) begin
                    hit = i;
                end
            end
            `CHK("first valid irq", first[c], hit)
        end
        m_chk(ipm_pkg::M_FIFO_CS, 16'h8182);
        s_wr(ipm_pkg::S_TX_DATA, 16'hBEEF);
        m_chk(ipm_pkg::M_FIFO_CS, 16'h818A);
        for (int i = 1; i <= DEPTH; i++) begin
            m_chk(ipm_pkg::M_RX_DATA, 16'hC000 + 16'(i));
        end
        m_chk(ipm_pkg::M_RX_DATA, 16'h0000);
        m_chk(ipm_pkg::M_FIFO_CS, 16'h818D);
        u_ipm_master_model.m_wr(ipm_pkg::M_FIFO_CS, 16'h8080);
        m_chk(ipm_pkg::M_FIFO_CS, 16'h8189);
        u_ipm_master_model.m_wr(ipm_pkg::M_FIFO_CS, 16'h8000);
        m_chk(ipm_pkg::M_FIFO_CS, 16'h8101);
    endtask
    // Count reset-event pulses while the master enters reset
    task automatic rst_edge(output int n);
        n = 0;
        u_ipm_master_model.m_in_reset = 1'b0;
        repeat (2) @(posedge clk);
        #1 u_ipm_master_model.m_in_reset = 1'b1;
        repeat (4) begin
            @(posedge clk);
            #1 if (m_rst_irq === 1'b1) n++;
        end
    endtask
    // Cross requests, acknowledges, power state and reset event
    task automatic t_xreq;
        int n;
        u_ipm_master_model.ack_dly = 3; // A slow master answer
        s_wr(ipm_pkg::S_CTRL, 16'h0200);
        `CHK("slave request", 1'b1, s2m_req_irq)
        repeat (8) @(posedge clk);
        s_chk(ipm_pkg::S_STAT, 16'h0100);
        `CHK("master ack error", 1'b0, m_ack_err)
        s_wr(ipm_pkg::S_CTRL, 16'h0100);
        `CHK("slave ack error", 1'b1, s_ack_err)
        u_ipm_master_model.m_irq_req = 1'b1;
        repeat (2) @(posedge clk);
        #1 `CHK("slave ack error", 1'b0, s_ack_err)
        `CHK("slave ack", 1'b1, s_ack_out)
        for (int p = 0; p < 4; p++) begin
            u_ipm_master_model.m_low_power = p[1:0];
            s_chk(ipm_pkg::S_STAT, {2'h0, p[1:0], 4'h2, 8'h00});
        end
        s_wr(ipm_pkg::S_CTRL, 16'h0080);
        rst_edge(n);
        `CHK("reset events", 1, n)
        s_chk(ipm_pkg::S_STAT, 16'hB200);
        s_wr(ipm_pkg::S_CTRL, 16'h0000);
        rst_edge(n);
        `CHK("reset events", 0, n)
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (6) @(posedge clk);
        #1 rst = 1'b0;
        t_reset();
        t_mbx();
        t_m2s();
        t_s2m();
        t_xreq();
        close_out();
    end
    // Watchdog, well past the few hundred cycles the run needs
    initial begin
        #200000;
        n_errors++;
        close_out();
    end
endmodule
`default_nettype wire
